// File: rtl/sbs_top.sv
// serial port bit-rate generator, status flags and apb register file
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
// Function
// - prescale divisor is field value plus one
// - rate divisor is two to field plus one
// - bus clock, prescaler, rate divider, bit clock
// - bit-rate register accessible at any time
// - unimplemented status bits zero, writes ignored
// - receive-full set when transfer completes
// - receive-full cleared by status then data read
// - tx-empty cleared by status read then write
// - data write without armed status read ignored
// - tx-empty interrupt when flag and enable set
// - tx-empty set when byte enters shifter
// - idle master port without mode fault loads shifter within two cycles
// - transfer end loads waiting byte, else nothing
// - mode fault when master and select low
// - mode fault only master, enabled, no output
// - mode fault cleared by status read, control write
// - master transfer starts on data write
// - data reads receive buffer, writes transmit buffer
module sbs_top (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic selectIn_n,
    input wire logic misoIn,
    output logic mosiOut,
    output logic serialClock,
    output logic irq
);
    // ****************
    // registers and pin synchronisers
    // ****************
    logic [7:0] bitRate_r;
    logic [7:0] control1_r;
    logic [7:0] control2_r;
    logic [7:0] txBuf_r;
    logic [7:0] rxBuf_r;
    logic [7:0] shift_r;
    logic txFull_r;
    logic rxFull_r;
    logic modeFault_r;
    logic txArm_r;
    logic rxArm_r;
    logic mfArm_r;
    logic busy_r;
    logic [3:0] edgeCnt_r;
    logic [2:0] irqStat_r;
    logic [2:0] irqMask_r;
    logic [1:0] ssSync_r;
    logic [1:0] misoSync_r;
    logic [7:0] rxShift_r;
    logic [1:0] sampleDly_r;
    logic [1:0] lastDly_r;
    logic riseTick;
    logic prescTick;
    logic halfTick;
    logic wrAcc;
    logic rdAcc;
    logic [7:0] status;
    logic txEmpty;
    logic faultInput;
    logic dataWrOk;
    logic loadShift;
    logic xferDone;
    logic isMaster;

    // register decode helpers
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return a == ofs;
    endfunction

    assign wrAcc = psel && penable && pwrite;
    assign rdAcc = psel && penable && !pwrite;
    assign isMaster = control1_r[sbs_pkg::C1_MASTER_BIT];
    assign txEmpty = !txFull_r;
    // status with unimplemented bits tied low
    assign status = {rxFull_r, 1'b0, txEmpty, modeFault_r, 4'h0};
    assign faultInput = isMaster && control2_r[sbs_pkg::C2_MODE_FAULT_ENABLE_BIT]
        && !control1_r[sbs_pkg::C1_SELECT_OUTPUT_ENABLE_BIT];
    assign dataWrOk = wrAcc && hit(paddr, sbs_pkg::OFS_SERIAL_DATA) && txArm_r;
    assign loadShift = txFull_r && !busy_r && isMaster && !modeFault_r;
    assign xferDone = busy_r && halfTick && (edgeCnt_r == 4'hf);

    // ****************
    // bit-rate generator
    // ****************
    sbs_prescaler u_presc (
        .clock(clock),
        .rst_n(rst_n),
        .run(busy_r),
        .prescaleSel(bitRate_r[sbs_pkg::PRESCALE_LSB +: 3]),
        .tick(prescTick)
    );
    sbs_rate_divider #(.CNT_W(8)) u_rate (
        .clock(clock),
        .rst_n(rst_n),
        .run(busy_r),
        .inTick(prescTick),
        .rateSel(bitRate_r[sbs_pkg::RATE_LSB +: 3]),
        .halfTick(halfTick)
    );

    // ****************
    // apb slave
    // ****************
    // pin inputs pass two flops
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ssSync_r <= 2'h3;
            misoSync_r <= 2'h0;
        end else begin
            ssSync_r <= {ssSync_r[0], selectIn_n};
            misoSync_r <= {misoSync_r[0], misoIn};
        end
    end

    // writable configuration, bit-rate open at any time
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bitRate_r <= sbs_pkg::BIT_RATE_RST;
            control1_r <= sbs_pkg::CONTROL1_RST;
            control2_r <= sbs_pkg::CONTROL2_RST;
            irqMask_r <= sbs_pkg::IRQ_MASK_RST;
        end else if (wrAcc) begin
            if (hit(paddr, sbs_pkg::OFS_BIT_RATE)) begin
                bitRate_r <= pwdata[7:0] & 8'h77;
            end
            if (hit(paddr, sbs_pkg::OFS_CONTROL1)) begin
                control1_r <= pwdata[7:0];
            end
            if (hit(paddr, sbs_pkg::OFS_CONTROL2)) begin
                control2_r <= pwdata[7:0] & 8'h1b;
            end
            if (hit(paddr, sbs_pkg::OFS_IRQ_MASK)) begin
                irqMask_r <= pwdata[2:0];
            end
        end
    end

    // read mux, answer in the access cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            if (psel && !penable) begin
                case (paddr)
                    sbs_pkg::OFS_BIT_RATE: prdata <= {24'h0, bitRate_r};
                    sbs_pkg::OFS_FLAG_STATUS: prdata <= {24'h0, status};
                    sbs_pkg::OFS_SERIAL_DATA: prdata <= {24'h0, rxBuf_r};
                    sbs_pkg::OFS_CONTROL1: prdata <= {24'h0, control1_r};
                    sbs_pkg::OFS_CONTROL2: prdata <= {24'h0, control2_r};
                    sbs_pkg::OFS_IRQ_STATUS: prdata <= {29'h0, irqStat_r};
                    sbs_pkg::OFS_IRQ_MASK: prdata <= {29'h0, irqMask_r};
                    default: pslverr <= 1'b0;
                endcase
                if (!(paddr inside {sbs_pkg::OFS_BIT_RATE, sbs_pkg::OFS_FLAG_STATUS,
                        sbs_pkg::OFS_SERIAL_DATA, sbs_pkg::OFS_CONTROL1,
                        sbs_pkg::OFS_CONTROL2, sbs_pkg::OFS_IRQ_STATUS,
                        sbs_pkg::OFS_IRQ_MASK})) begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ****************
    // status flag sequences
    // ****************
    // arm flags record a status read that saw the flag set
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txArm_r <= 1'b0;
            rxArm_r <= 1'b0;
            mfArm_r <= 1'b0;
        end else begin
            if (rdAcc && hit(paddr, sbs_pkg::OFS_FLAG_STATUS)) begin
                txArm_r <= txEmpty;
                rxArm_r <= rxFull_r;
                mfArm_r <= modeFault_r;
            end else begin
                if (dataWrOk) txArm_r <= 1'b0;
                if (rdAcc && hit(paddr, sbs_pkg::OFS_SERIAL_DATA)) rxArm_r <= 1'b0;
                if (wrAcc && hit(paddr, sbs_pkg::OFS_CONTROL1)) mfArm_r <= 1'b0;
            end
        end
    end

    // transmit buffer: filled by armed write, drained into shifter
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txFull_r <= 1'b0;
            txBuf_r <= 8'h0;
        end else if (dataWrOk) begin
            txBuf_r <= pwdata[7:0];
            txFull_r <= 1'b1;
        end else if (loadShift || (xferDone && txFull_r)) begin
            txFull_r <= 1'b0;
        end
    end

    // receive buffer and flag; a completing transfer wins over a clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxFull_r <= 1'b0;
            rxBuf_r <= 8'h0;
        end else if (lastDly_r[1]) begin
            if (!rxFull_r) rxBuf_r <= {rxShift_r[6:0], misoSync_r[1]}; // overrun drops data
            rxFull_r <= 1'b1;
        end else if (rxArm_r && rdAcc && hit(paddr, sbs_pkg::OFS_SERIAL_DATA)) begin
            rxFull_r <= 1'b0;
        end
    end

    // mode fault detection and clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            modeFault_r <= 1'b0;
        end else if (faultInput && !ssSync_r[1]) begin
            modeFault_r <= 1'b1;
        end else if (mfArm_r && wrAcc && hit(paddr, sbs_pkg::OFS_CONTROL1)) begin
            modeFault_r <= 1'b0;
        end
    end

    // ****************
    // master shifter, msb first
    // ****************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            edgeCnt_r <= 4'h0;
            shift_r <= 8'h0;
            serialClock <= 1'b0;
            mosiOut <= 1'b0;
        end else if (!busy_r) begin
            serialClock <= 1'b0;
            if (loadShift) begin
                busy_r <= 1'b1;
                shift_r <= txBuf_r;
                mosiOut <= txBuf_r[7];
                edgeCnt_r <= 4'h0;
            end
        end else if (modeFault_r) begin
            busy_r <= 1'b0;
            serialClock <= 1'b0;
        end else if (halfTick) begin
            serialClock <= !serialClock;
            edgeCnt_r <= edgeCnt_r + 4'h1;
            if (edgeCnt_r[0] && edgeCnt_r != 4'hf) begin
                shift_r <= {shift_r[6:0], 1'b0};
                mosiOut <= shift_r[6];
            end
            if (xferDone) begin
                busy_r <= txFull_r;
                if (txFull_r) begin
                    shift_r <= txBuf_r;
                    mosiOut <= txBuf_r[7];
                end
            end
        end
    end

    // miso leaves the synchroniser two edges late, so sample two cycles after each rise
    assign riseTick = busy_r && !modeFault_r && halfTick && !edgeCnt_r[0];
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sampleDly_r <= 2'h0;
            lastDly_r <= 2'h0;
            rxShift_r <= 8'h0;
        end else begin
            sampleDly_r <= {sampleDly_r[0], riseTick};
            lastDly_r <= {lastDly_r[0], riseTick && edgeCnt_r == 4'he};
            if (sampleDly_r[1]) begin
                rxShift_r <= {rxShift_r[6:0], misoSync_r[1]};
            end
        end
    end

    // ****************
    // interrupts
    // ****************
    // sticky events: tx empty, mode fault, transfer done; write one clears
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irqStat_r <= 3'h0;
        end else begin
            irqStat_r <= (irqStat_r & ~((wrAcc && hit(paddr, sbs_pkg::OFS_IRQ_STATUS))
                ? pwdata[2:0] : 3'h0))
                | {xferDone, faultInput && !ssSync_r[1], txEmpty};
        end
    end

    // level request from enabled tx empty or any unmasked event
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (txEmpty && control1_r[sbs_pkg::C1_TXIE_BIT])
                || |(irqStat_r & irqMask_r);
        end
    end

    // ****************
    // checks
    // ****************
    property p_status_zero;
        @(posedge clock) disable iff (!rst_n)
        (psel && !penable && !pwrite && paddr == sbs_pkg::OFS_FLAG_STATUS)
            |=> (prdata[6] == 1'b0 && prdata[3:0] == 4'h0);
    endproperty
    a_status_zero: assert property (p_status_zero) else $error("status spare bits set");

    property p_unarmed_write;
        @(posedge clock) disable iff (!rst_n)
        (wrAcc && hit(paddr, sbs_pkg::OFS_SERIAL_DATA) && !txArm_r && !txFull_r)
            |=> !txFull_r;
    endproperty
    a_unarmed_write: assert property (p_unarmed_write) else $error("unarmed data write taken");

    property p_rx_set;
        @(posedge clock) disable iff (!rst_n)
        lastDly_r[1] |=> rxFull_r;
    endproperty
    a_rx_set: assert property (p_rx_set) else $error("receive full not set");

    property p_idle_load;
        @(posedge clock) disable iff (!rst_n)
        (dataWrOk && !busy_r && isMaster && !modeFault_r) |-> ##[1:2] (txEmpty && busy_r);
    endproperty
    a_idle_load: assert property (p_idle_load) else $error("idle load too slow");

    property p_fault_gate;
        @(posedge clock) disable iff (!rst_n)
        (!faultInput && !modeFault_r) |=> !modeFault_r;
    endproperty
    a_fault_gate: assert property (p_fault_gate) else $error("mode fault without enable");

    property p_fault_set;
        @(posedge clock) disable iff (!rst_n)
        (faultInput && !ssSync_r[1]) |=> modeFault_r;
    endproperty
    a_fault_set: assert property (p_fault_set) else $error("mode fault missed");

    property p_irq_tx;
        @(posedge clock) disable iff (!rst_n)
        (txEmpty && control1_r[sbs_pkg::C1_TXIE_BIT]) |=> irq;
    endproperty
    a_irq_tx: assert property (p_irq_tx) else $error("tx interrupt missing");

    property p_rate_keep;
        @(posedge clock) disable iff (!rst_n)
        (wrAcc && paddr == sbs_pkg::OFS_BIT_RATE) |=> bitRate_r == ($past(pwdata[7:0]) & 8'h77);
    endproperty
    a_rate_keep: assert property (p_rate_keep) else $error("bit-rate write lost");
endmodule

// File: rtl/sbs_pkg.sv
// shared constants for the serial port bit-rate and status block
package sbs_pkg;
    // ****************
    // register map
    // ****************
    localparam logic [7:0] OFS_BIT_RATE = 8'h00;
    localparam logic [7:0] OFS_FLAG_STATUS = 8'h04;
    localparam logic [7:0] OFS_SERIAL_DATA = 8'h08;
    localparam logic [7:0] OFS_CONTROL1 = 8'h0c;
    localparam logic [7:0] OFS_CONTROL2 = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
    // ****************
    // field positions
    // ****************
    localparam int PRESCALE_LSB = 4;
    localparam int RATE_LSB = 0;
    localparam int RXFULL_BIT = 7;
    localparam int TXEMPTY_BIT = 5;
    localparam int MODEFAULT_BIT = 4;
    localparam int C1_TXIE_BIT = 5;
    localparam int C1_MASTER_BIT = 4;
    localparam int C1_SELECT_OUTPUT_ENABLE_BIT = 1;
    localparam int C2_MODE_FAULT_ENABLE_BIT = 4;
    localparam int C1_SPE_BIT = 6;
    // ****************
    // reset values and counts
    // ****************
    localparam logic [7:0] BIT_RATE_RST = 8'h00;
    localparam logic [7:0] CONTROL1_RST = 8'h04;
    localparam logic [7:0] CONTROL2_RST = 8'h00;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    localparam logic [3:0] BITS_PER_FRAME = 4'h8;
    localparam int RATE_CNT_W = 12;
endpackage

// File: rtl/sbs_prescaler.sv
// first divider stage: bus clock divided by one to eight
`timescale 1ns/1ps
module sbs_prescaler (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] prescaleSel,
    output logic tick
);
    logic [2:0] cnt_r;

    // counts 0..sel, pulses on the wrap
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 3'h0;
        end else if (!run || cnt_r >= prescaleSel) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_r + 3'h1;
        end
    end
    assign tick = run && (cnt_r >= prescaleSel);
endmodule

// File: rtl/sbs_rate_divider.sv
// second divider stage: prescaler ticks divided by 2 to 256
`timescale 1ns/1ps
module sbs_rate_divider #(
    parameter int CNT_W = 8
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic run,
    input wire logic inTick,
    input wire logic [2:0] rateSel,
    output logic halfTick
);
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] halfLast;

    // each half bit is 2^sel input ticks
    assign halfLast = CNT_W'((1 << rateSel) - 1);
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (!run) begin
            cnt_r <= '0;
        end else if (inTick) begin
            cnt_r <= (cnt_r >= halfLast) ? '0 : cnt_r + 1'b1;
        end
    end
    assign halfTick = run && inTick && (cnt_r >= halfLast);
endmodule

// File: sim/sbs_slave_model.sv
// behavioural serial slave facing the master bit clock of the block
`timescale 1ns/1ps
module sbs_slave_model (
    input wire logic serialClock,
    input wire logic mosiIn,
    input wire logic [7:0] reply,
    output logic misoOut,
    output logic [7:0] lastByte,
    output int nGot
);
    int nRise = 0;
    int idx = 0;
    logic [7:0] sh = 8'h00;
    initial begin
        lastByte = 8'h00;
        nGot = 0;
    end
    // sample the master data on rising bit clock, msb first, count whole bytes
    always @(posedge serialClock) begin
        sh = {sh[6:0], mosiIn};
        nRise = nRise + 1;
        if (nRise == 8) begin
            lastByte = sh;
            nGot = nGot + 1;
            nRise = 0;
        end
    end
    // next reply bit goes out half a bit after each sample
    always @(negedge serialClock) begin
        idx = nRise;
    end
    assign misoOut = reply[3'(7 - idx)];
endmodule

// File: sim/sbs_top_tb_top.sv
// self-checking bench for the bit-rate generator and status flags
`timescale 1ns/1ps
module sbs_top_tb_top;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic selectIn_n = 1'b1;
    logic [7:0] reply = 8'h3c;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic misoIn;
    logic mosiOut;
    logic serialClock;
    logic irq;
    logic [7:0] lastByte;
    int nGot;
    int fails = 0;
    int n_compared = 0;
    logic [31:0] rv;
    logic lastErr;

    // ****************
    // clock and instances
    // ****************
    always #10 clock = ~clock;
    sbs_top dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .selectIn_n(selectIn_n), .misoIn(misoIn), .mosiOut(mosiOut),
        .serialClock(serialClock), .irq(irq));
    sbs_slave_model peer (.serialClock(serialClock), .mosiIn(mosiOut), .reply(reply),
        .misoOut(misoIn), .lastByte(lastByte), .nGot(nGot));

    // ****************
    // shared tasks
    // ****************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer: setup, access held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rv);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, rv);
        chk(rv, exp);
    endtask
    task automatic waitGot(input int target);
        while (nGot < target) begin
            @(posedge clock);
        end
    endtask

    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        chk({31'h0, irq}, 32'h0);
        rd(sbs_pkg::OFS_BIT_RATE, {24'h0, sbs_pkg::BIT_RATE_RST});
        rd(sbs_pkg::OFS_CONTROL1, {24'h0, sbs_pkg::CONTROL1_RST});
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h20);
        wr(sbs_pkg::OFS_FLAG_STATUS, 32'hff);
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h20);
        rd(8'h1c, 32'h0);
        chk({31'h0, lastErr}, 32'h1);
        wr(sbs_pkg::OFS_BIT_RATE, 32'h52);
        rd(sbs_pkg::OFS_BIT_RATE, 32'h52);
    endtask
    // one frame at a given divider setting, half bit measured in bus cycles
    task automatic xfer(input logic [2:0] p, input logic [2:0] r, input logic [7:0] d);
        int m;
        int b;
        logic s;
        b = nGot;
        reply <= ~d;
        wr(sbs_pkg::OFS_BIT_RATE, {25'h0, p, 1'b0, r});
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h20);
        wr(sbs_pkg::OFS_SERIAL_DATA, {24'h0, d});
        m = 0;
        while (serialClock === 1'b0) begin
            @(posedge clock);
            m++;
        end
        s = serialClock;
        m = 0;
        do begin
            @(posedge clock);
            m++;
        end while (serialClock === s);
        chk(32'(m), 32'((int'(p) + 1) << r));
        waitGot(b + 1);
        chk({24'h0, lastByte}, {24'h0, d});
        repeat (3) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'ha0);
        rd(sbs_pkg::OFS_SERIAL_DATA, {24'h0, ~d});
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h20);
    endtask
    // queue a second byte behind a running one, then an unarmed write
    task automatic t_queue();
        int b;
        b = nGot;
        wr(sbs_pkg::OFS_BIT_RATE, 32'h01);
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h20);
        wr(sbs_pkg::OFS_SERIAL_DATA, 32'h81);
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h20);
        wr(sbs_pkg::OFS_SERIAL_DATA, 32'h7e);
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h00);
        waitGot(b + 1);
        chk({24'h0, lastByte}, 32'h81);
        waitGot(b + 2);
        chk({24'h0, lastByte}, 32'h7e);
        wr(sbs_pkg::OFS_SERIAL_DATA, 32'h55);
        repeat (80) @(posedge clock);
        chk(32'(nGot), 32'(b + 2));
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'ha0);
        rd(sbs_pkg::OFS_SERIAL_DATA, 32'h3c);
    endtask
    // transmit-empty request and the masked transfer-done event
    task automatic t_irq();
        wr(sbs_pkg::OFS_CONTROL1, 32'h74);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h1);
        wr(sbs_pkg::OFS_CONTROL1, 32'h54);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        wr(sbs_pkg::OFS_IRQ_STATUS, 32'h07);
        chk({31'h0, irq}, 32'h0);
        xfer(3'h0, 3'h0, 8'h96);
        wr(sbs_pkg::OFS_IRQ_MASK, 32'h04);
        apb(1'b0, sbs_pkg::OFS_IRQ_STATUS, 32'h0, rv);
        chk(rv & 32'h4, 32'h4);
        chk({31'h0, irq}, 32'h1);
        wr(sbs_pkg::OFS_IRQ_STATUS, 32'h04);
        repeat (2) @(posedge clock);
        chk({31'h0, irq}, 32'h0);
        wr(sbs_pkg::OFS_IRQ_MASK, 32'h00);
    endtask
    // select pin low as master: fault disabled, select output on, then fault armed
    task automatic t_fault();
        selectIn_n <= 1'b0;
        wr(sbs_pkg::OFS_CONTROL2, 32'h00);
        repeat (6) @(posedge clock);
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h20);
        wr(sbs_pkg::OFS_CONTROL1, 32'h56);
        wr(sbs_pkg::OFS_CONTROL2, 32'h10);
        repeat (6) @(posedge clock);
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h20);
        wr(sbs_pkg::OFS_CONTROL1, 32'h54);
        repeat (6) @(posedge clock);
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h30);
        selectIn_n <= 1'b1;
        repeat (6) @(posedge clock);
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h30);
        wr(sbs_pkg::OFS_CONTROL1, 32'h54);
        rd(sbs_pkg::OFS_FLAG_STATUS, 32'h20);
    endtask

    // ****************
    // run control
    // ****************
    task automatic conclude();
        if (fails == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // cut a hang short well after the expected run length
    initial begin
        #400000;
        fails++;
        conclude();
    end
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        wr(sbs_pkg::OFS_CONTROL1, 32'h54);
        xfer(3'h0, 3'h0, 8'ha5);
        xfer(3'h2, 3'h1, 8'h1e);
        xfer(3'h7, 3'h3, 8'hc3);
        t_queue();
        t_irq();
        t_fault();
        conclude();
    end
endmodule
